/* File: verilog/eeprom_register_burst_loader.v */
// Register-burst loader and command/data registers of the serial EEPROM controller
`include "eeprom_loader_map.vh"
`default_nettype none

module eeprom_register_burst_loader (
  input  wire        sys_clk,
  input  wire        rst,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // Byte engine towards the EEPROM
  output reg         eeprom_req,
  output reg         eeprom_we,
  output reg  [15:0] eeprom_addr,
  output reg  [7:0]  eeprom_wdata,
  input  wire        eeprom_done,
  input  wire [7:0]  eeprom_rdata,
  input  wire        eeprom_timeout,
  // Direct register write port
  output reg         cfg_wr_valid,
  output reg  [9:0]  cfg_wr_addr,
  output reg  [31:0] cfg_wr_data,
  input  wire        switch_a,
  input  wire        phy_mgmt_busy,
  // Strap pin and status
  input  wire        eeprom_size_strap,
  output wire        device_ready
);

  // Controller states
  localparam [1:0] ST_IDLE  = 2'd0;
  localparam [1:0] ST_REQ   = 2'd1;
  localparam [1:0] ST_WRITE = 2'd2;
  localparam [1:0] ST_DONE  = 2'd3;

  // Content phases
  localparam [2:0] PH_VALID = 3'd0;
  localparam [2:0] PH_SKIP  = 3'd1;
  localparam [2:0] PH_FLAG  = 3'd2;
  localparam [2:0] PH_COUNT = 3'd3;
  localparam [2:0] PH_HDRA  = 3'd4;
  localparam [2:0] PH_HDRC  = 3'd5;
  localparam [2:0] PH_DATA  = 3'd6;
  localparam [2:0] PH_HOST  = 3'd7;

  reg [1:0]  state;
  reg [2:0]  phase;
  reg        controller_busy;
  reg        loading;
  reg        load_pending;
  reg [2:0]  operation_select;
  reg [15:0] cmd_addr;
  reg        controller_timeout;
  reg        loader_overflow;
  reg [31:0] eeprom_data;
  reg [15:0] ptr;
  reg [15:0] limit;
  reg [7:0]  burst_total;
  reg [7:0]  word_left;
  reg [7:0]  dword_addr;
  reg [1:0]  byte_idx;
  reg [31:0] word;
  reg        strap_meta;
  reg        strap_sync;

  // Largest address of the range a strap setting selects
  function [15:0] limit_of;
    input strap;
    begin
      limit_of = strap ? `LIMIT_LARGE : `LIMIT_SMALL;
    end
  endfunction

  wire [31:0] command_view;
  wire        mapped;
  wire        wr_access;
  wire        wr_cmd;
  wire        wr_data;

  // Command register as software sees it
  assign command_view = {controller_busy, operation_select, 10'h000,
                         loader_overflow, controller_timeout, cmd_addr};

  // APB decode; zero wait states, error on unmapped words
  assign mapped    = (paddr == `OFS_EEPROM_COMMAND) || (paddr == `OFS_EEPROM_DATA);
  assign pready    = 1'b1;
  assign pslverr   = psel & penable & ~mapped;
  assign wr_access = psel & penable & pwrite;
  assign wr_cmd    = wr_access & (paddr == `OFS_EEPROM_COMMAND);
  assign wr_data   = wr_access & (paddr == `OFS_EEPROM_DATA);

  // Ready is low for as long as the loader owns the device
  assign device_ready = ~loading;

  // Read data latched in the setup phase so it comes from a flip-flop
  always @(posedge sys_clk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      if (paddr == `OFS_EEPROM_COMMAND)
        prdata <= command_view;
      else if (paddr == `OFS_EEPROM_DATA)
        prdata <= eeprom_data;
      else
        prdata <= 32'h0000_0000;
    end
  end

  // The strap pin is asynchronous; only the second stage is read.
  // It keeps sampling through reset so the first load sees the pin.
  always @(posedge sys_clk) begin
    strap_meta <= eeprom_size_strap;
    strap_sync <= strap_meta;
  end

  // Main sequencer: host commands, content walk and register writes
  always @(posedge sys_clk) begin
    if (rst) begin
      state              <= ST_IDLE;
      phase              <= PH_VALID;
      controller_busy    <= 1'b0;
      loading            <= 1'b0;
      load_pending       <= 1'b1;
      operation_select   <= 3'h0;
      cmd_addr           <= 16'h0000;
      controller_timeout <= 1'b0;
      loader_overflow    <= 1'b0;
      eeprom_data        <= `RESET_DATA;
      ptr                <= 16'h0000;
      limit              <= `LIMIT_SMALL;
      burst_total        <= 8'h00;
      word_left          <= 8'h00;
      dword_addr         <= 8'h00;
      byte_idx           <= 2'd0;
      word               <= 32'h0000_0000;
      eeprom_req         <= 1'b0;
      eeprom_we          <= 1'b0;
      eeprom_addr        <= 16'h0000;
      eeprom_wdata       <= 8'h00;
      cfg_wr_valid       <= 1'b0;
      cfg_wr_addr        <= 10'h000;
      cfg_wr_data        <= 32'h0000_0000;
    end else begin
      cfg_wr_valid <= 1'b0;
      // Software clears the timeout flag by writing one; a new timeout wins
      if (wr_cmd && pwdata[`CMD_TIMEOUT_BIT])
        controller_timeout <= 1'b0;
      if (wr_cmd && pwdata[`CMD_OVERFLOW_BIT])
        loader_overflow <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (load_pending) begin
            // Busy rises on the first edge after reset or reload
            load_pending    <= 1'b0;
            controller_busy <= 1'b1;
            loading         <= 1'b1;
            limit           <= limit_of(strap_sync);
            ptr             <= `FIRST_BYTE;
            phase           <= PH_VALID;
            eeprom_we       <= 1'b0;
            state           <= ST_REQ;
          end else begin
            // Data, operation and address fields take host writes only while idle; their writes during busy are dropped
            if (wr_data)
              eeprom_data <= pwdata;
            if (wr_cmd) begin
              operation_select <= pwdata[`CMD_OP_HI:`CMD_OP_LO];
              cmd_addr         <= pwdata[`CMD_ADDR_HI:`CMD_ADDR_LO];
            end
            if (wr_cmd && pwdata[`CMD_BUSY_BIT]) begin
              case (pwdata[`CMD_OP_HI:`CMD_OP_LO])
                `OP_READ, `OP_WRITE: begin
                  controller_busy <= 1'b1;
                  ptr             <= pwdata[`CMD_ADDR_HI:`CMD_ADDR_LO];
                  limit           <= limit_of(strap_sync);
                  eeprom_we       <= pwdata[`CMD_OP_LO];
                  eeprom_wdata    <= eeprom_data[7:0];
                  phase           <= PH_HOST;
                  state           <= ST_REQ;
                end
                `OP_RELOAD: begin
                  load_pending <= 1'b1;
                end
                default: begin
                  // Reserved codes complete at once
                  controller_busy <= 1'b0;
                end
              endcase
            end
          end
        end
        ST_REQ: begin
          if (!eeprom_req) begin
            if (ptr > limit) begin
              // Out of EEPROM space: stop and flag it
              loader_overflow <= 1'b1;
              controller_busy <= 1'b0;
              loading         <= 1'b0;
              state           <= ST_IDLE;
            end else begin
              eeprom_addr <= ptr;
              eeprom_req  <= 1'b1;
            end
          end else if (eeprom_timeout) begin
            // No device answered; busy drops only with the timeout flag
            eeprom_req         <= 1'b0;
            controller_timeout <= 1'b1;
            controller_busy    <= 1'b0;
            loading            <= 1'b0;
            state              <= ST_IDLE;
          end else if (eeprom_done) begin
            eeprom_req <= 1'b0;
            ptr        <= ptr + 16'h0001;
            case (phase)
              PH_VALID: begin
                if (eeprom_rdata == `VALID_FLAG) begin
                  phase <= PH_SKIP;
                end else begin
                  // Blank part: strap values stay as they are
                  controller_busy <= 1'b0;
                  loading         <= 1'b0;
                  state           <= ST_IDLE;
                end
              end
              PH_SKIP: begin
                // MAC and strap bytes belong to other loaders
                if (ptr == `LAST_STRAP_BYTE)
                  phase <= PH_FLAG;
              end
              PH_FLAG: begin
                if (eeprom_rdata == `VALID_FLAG) begin
                  phase <= PH_COUNT;
                end else begin
                  controller_busy <= 1'b0;
                  loading         <= 1'b0;
                  state           <= ST_IDLE;
                end
              end
              PH_COUNT: begin
                burst_total <= eeprom_rdata;
                if (eeprom_rdata == 8'h00) begin
                  controller_busy <= 1'b0;
                  loading         <= 1'b0;
                  state           <= ST_IDLE;
                end else begin
                  phase <= PH_HDRA;
                end
              end
              PH_HDRA: begin
                dword_addr <= eeprom_rdata;
                phase      <= PH_HDRC;
              end
              PH_HDRC: begin
                word_left <= eeprom_rdata;
                byte_idx  <= 2'd0;
                if (eeprom_rdata != 8'h00) begin
                  phase <= PH_DATA;
                end else if (burst_total == 8'h01) begin
                  controller_busy <= 1'b0;
                  loading         <= 1'b0;
                  state           <= ST_IDLE;
                end else begin
                  burst_total <= burst_total - 8'h01;
                  phase       <= PH_HDRA;
                end
              end
              PH_DATA: begin
                // First byte lands in the top lane
                word     <= {word[23:0], eeprom_rdata};
                byte_idx <= byte_idx + 2'd1;
                if (byte_idx == 2'd3)
                  state <= ST_WRITE;
              end
              default: begin
                // Host access ends here; busy low marks valid read data
                if (!eeprom_we)
                  eeprom_data <= {24'h00_0000, eeprom_rdata};
                controller_busy <= 1'b0;
                state           <= ST_IDLE;
              end
            endcase
          end
        end
        ST_WRITE: begin
          // Holding off avoids clobbering a switch or PHY access in flight
          if (!switch_a && !phy_mgmt_busy) begin
            cfg_wr_valid <= 1'b1;
            cfg_wr_addr  <= {dword_addr, 2'b00};
            cfg_wr_data  <= word;
            dword_addr   <= dword_addr + 8'h01;
            word_left    <= word_left - 8'h01;
            byte_idx     <= 2'd0;
            state        <= ST_REQ;
            if (word_left != 8'h01) begin
              phase <= PH_DATA;
            end else if (burst_total == 8'h01) begin
              state <= ST_DONE;
            end else begin
              burst_total <= burst_total - 8'h01;
              phase       <= PH_HDRA;
            end
          end
        end
        ST_DONE: begin
          // Ready rises only after the last write pulse has gone out
          controller_busy <= 1'b0;
          loading         <= 1'b0;
          state           <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // eeprom_register_burst_loader

`default_nettype wire

/* File: verilog/eeprom_loader_map.vh */
// Register offsets, field positions, codes and limits of the burst loader
`ifndef EEPROM_LOADER_MAP_VH
`define EEPROM_LOADER_MAP_VH

// Register byte addresses
`define OFS_EEPROM_COMMAND 12'h01B4
`define OFS_EEPROM_DATA    12'h01B8

// Command register fields
`define CMD_BUSY_BIT       31
`define CMD_OP_HI          30
`define CMD_OP_LO          28
`define CMD_OVERFLOW_BIT   17
`define CMD_TIMEOUT_BIT    16
`define CMD_ADDR_HI        15
`define CMD_ADDR_LO        0

// Operation codes
`define OP_READ            3'h0
`define OP_WRITE           3'h3
`define OP_RELOAD          3'h7

// Content layout
`define VALID_FLAG         8'hA5
`define LAST_STRAP_BYTE    16'h0010
`define FIRST_BYTE         16'h0000

// Address limits per size strap, largest of each range
`define LIMIT_SMALL        16'h07FF
`define LIMIT_LARGE        16'hFFFF

// Reset values
`define RESET_COMMAND      32'h0000_0000
`define RESET_DATA         32'h0000_0000

`endif

/* File: verif/eeprom_register_burst_loader_asserts.sv */
// Port checker for the EEPROM register burst loader
`include "eeprom_loader_map.vh"
`default_nettype none
module loader_checker (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        eeprom_req,
  input wire logic        eeprom_we,
  input wire logic [15:0] eeprom_addr,
  input wire logic        eeprom_done,
  input wire logic        eeprom_timeout,
  input wire logic        cfg_wr_valid,
  input wire logic        switch_a,
  input wire logic        phy_mgmt_busy,
  input wire logic        eeprom_size_strap,
  input wire logic        device_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // A load byte answered, then the one-cycle gap before the next fetch
  sequence s_byte_done;
    eeprom_req && eeprom_done && !device_ready;
  endsequence
  sequence s_restart;
    !eeprom_req ##1 eeprom_req;
  endsequence
  property p_seq_addr;
    s_byte_done ##1 s_restart |-> eeprom_addr == $past(eeprom_addr, 2) + 16'h0001;
  endproperty
  a_seq_addr: assert property (p_seq_addr) else $error("fetch skipped a byte");
  property p_hold;
    eeprom_req && !eeprom_done && !eeprom_timeout |=>
      eeprom_req && $stable(eeprom_addr) && $stable(eeprom_we);
  endproperty
  a_hold: assert property (p_hold) else $error("request moved early");
  property p_drop;
    eeprom_req && (eeprom_done || eeprom_timeout) |=> !eeprom_req;
  endproperty
  a_drop: assert property (p_drop) else $error("request kept after answer");
  // A write stalled by either busy flag must not issue
  property p_wait;
    cfg_wr_valid |-> !$past(switch_a) && !$past(phy_mgmt_busy);
  endproperty
  a_wait: assert property (p_wait) else $error("write while busy");
  property p_pulse;
    cfg_wr_valid |=> !cfg_wr_valid;
  endproperty
  a_pulse: assert property (p_pulse) else $error("write pulse too long");
  property p_load_only;
    cfg_wr_valid |-> !device_ready;
  endproperty
  a_load_only: assert property (p_load_only) else $error("write while ready");
  property p_limit;
    eeprom_req && !device_ready |-> eeprom_size_strap || eeprom_addr <= `LIMIT_SMALL;
  endproperty
  a_limit: assert property (p_limit) else $error("fetch past limit");
  property p_rst_busy;
    $fell(rst) |=> !device_ready;
  endproperty
  a_rst_busy: assert property (p_rst_busy) else $error("not busy after reset");
  property p_first;
    $fell(rst) |-> ##2 eeprom_req && !eeprom_we && eeprom_addr == 16'h0000;
  endproperty
  a_first: assert property (p_first) else $error("load not from byte zero");
endmodule // loader_checker
`default_nettype wire

/* File: verif/eeprom_byte_model.sv */
// Behavioural serial EEPROM behind the byte request port
`default_nettype none
module eeprom_byte_model (
  input  wire logic        sys_clk,
  input  wire logic        eeprom_req,
  input  wire logic        eeprom_we,
  input  wire logic [15:0] eeprom_addr,
  input  wire logic [7:0]  eeprom_wdata,
  input  wire logic        absent,
  input  wire logic [3:0]  lat,
  output var  logic        eeprom_done,
  output var  logic [7:0]  eeprom_rdata,
  output var  logic        eeprom_timeout
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:65535];
  logic [3:0] cnt;
  initial begin
    eeprom_done = 1'b0;
    eeprom_timeout = 1'b0;
    eeprom_rdata = 8'h00;
    cnt = 4'h0;
  end
  // Answer after lat edges; data toggles off the answer cycle so stale bytes show
  always @(posedge sys_clk) begin
    eeprom_done <= 1'b0;
    eeprom_timeout <= 1'b0;
    eeprom_rdata <= ~eeprom_rdata;
    if (eeprom_req && !eeprom_done && !eeprom_timeout) begin
      cnt <= cnt + 4'h1;
      if (cnt >= lat) begin
        cnt <= 4'h0;
        if (absent) begin
          eeprom_timeout <= 1'b1;
        end else begin
          eeprom_done <= 1'b1;
          eeprom_rdata <= mem[eeprom_addr];
          if (eeprom_we) mem[eeprom_addr] <= eeprom_wdata;
        end
      end
    end else begin
      cnt <= 4'h0;
    end
  end
endmodule // eeprom_byte_model
`default_nettype wire

/* File: verif/eeprom_register_burst_loader_tb.sv */
// Self-checking bench for the EEPROM register burst loader
`include "eeprom_loader_map.vh"
`default_nettype none
`define CHK(nm, e, a) begin total_checks++; if ((a) !== (e)) begin mismatches++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, a); end end
module eeprom_register_burst_loader_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd, cfg_wr_data;
  logic [15:0] eeprom_addr;
  logic [9:0]  cfg_wr_addr;
  logic [7:0]  eeprom_wdata, eeprom_rdata;
  logic [7:0]  cyc = 8'h00;
  logic        pready, pslverr, eeprom_req, eeprom_we, eeprom_done, eeprom_timeout;
  logic        cfg_wr_valid, device_ready, err;
  logic        exp_on = 1'b1, switch_a = 1'b0, phy_mgmt_busy = 1'b0, strap = 1'b0;
  logic        absent = 1'b0;
  logic [3:0]  lat = 4'h0;
  logic [41:0] wr_seen;
  logic [41:0] exp_wr [0:2];
  int          mismatches = 0, total_checks = 0, wr_n = 0;
  eeprom_register_burst_loader dut (.sys_clk(sys_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .eeprom_req(eeprom_req), .eeprom_we(eeprom_we),
    .eeprom_addr(eeprom_addr), .eeprom_wdata(eeprom_wdata), .eeprom_done(eeprom_done),
    .eeprom_rdata(eeprom_rdata), .eeprom_timeout(eeprom_timeout),
    .cfg_wr_valid(cfg_wr_valid), .cfg_wr_addr(cfg_wr_addr), .cfg_wr_data(cfg_wr_data),
    .switch_a(switch_a), .phy_mgmt_busy(phy_mgmt_busy), .eeprom_size_strap(strap),
    .device_ready(device_ready));
  eeprom_byte_model em (.sys_clk(sys_clk), .eeprom_req(eeprom_req), .eeprom_we(eeprom_we),
    .eeprom_addr(eeprom_addr), .eeprom_wdata(eeprom_wdata), .absent(absent), .lat(lat),
    .eeprom_done(eeprom_done), .eeprom_rdata(eeprom_rdata), .eeprom_timeout(eeprom_timeout));
  always #10 sys_clk = ~sys_clk;
  assign wr_seen = {cfg_wr_addr, cfg_wr_data};
  // Busy flags and answer latency wander so writes stall and reads vary
  always @(posedge sys_clk) begin
    cyc <= cyc + 8'h01;
    switch_a <= (cyc[4:2] == 3'h0);
    phy_mgmt_busy <= (cyc[5:3] == 3'h5);
    lat <= {2'h0, cyc[7:6]};
  end
  // Direct writes are counted; those of the first load are also compared
  always @(posedge sys_clk) begin
    if (!rst && cfg_wr_valid === 1'b1) begin
      if (exp_on && wr_n < 3) `CHK("cfg write", exp_wr[wr_n], wr_seen)
      wr_n++;
    end
  end
  task automatic give_verdict();
    if (mismatches == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Setup, then access until pready is sampled high; release only after it
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (pready !== 1'b1) begin
      mismatches++;
      give_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Host only reads while busy, never rewrites the registers
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      apb(1'b0, `OFS_EEPROM_COMMAND, 32'h0000_0000);
      n++;
    end while (rd[31] !== 1'b0 && n < 10000);
    if (rd[31] !== 1'b0) begin
      mismatches++;
      give_verdict();
    end
  endtask
  initial begin
    exp_wr[0] = {10'h040, 32'h1112_1314};
    exp_wr[1] = {10'h080, 32'h2122_2324};
    exp_wr[2] = {10'h084, 32'h2526_2728};
    for (int i = 0; i < 65536; i++) em.mem[i] = 8'h00;
    em.mem[0] = `VALID_FLAG;
    em.mem[17] = `VALID_FLAG;
    em.mem[18] = 8'h02;
    em.mem[19] = 8'h10;
    em.mem[20] = 8'h01;
    em.mem[25] = 8'h20;
    em.mem[26] = 8'h02;
    for (int i = 0; i < 4; i++) em.mem[21 + i] = 8'(8'h11 + i);
    for (int i = 0; i < 8; i++) em.mem[27 + i] = 8'(8'h21 + i);
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    wait_idle();
    `CHK("load writes", 3, wr_n)
    `CHK("ready", 1'b1, device_ready)
    // Spoiled burst flag: reload ends with no register write
    em.mem[17] = 8'h00;
    apb(1'b1, `OFS_EEPROM_COMMAND, 32'hF000_0000);
    apb(1'b0, `OFS_EEPROM_COMMAND, 32'h0000_0000);
    `CHK("busy", 1'b1, rd[31])
    wait_idle();
    `CHK("no bursts", 3, wr_n)
    // Write one byte, then read it back
    apb(1'b1, `OFS_EEPROM_DATA, 32'h0000_005A);
    apb(1'b1, `OFS_EEPROM_COMMAND, 32'hB000_0030);
    wait_idle();
    apb(1'b1, `OFS_EEPROM_COMMAND, 32'h8000_0030);
    wait_idle();
    apb(1'b0, `OFS_EEPROM_DATA, 32'h0000_0000);
    `CHK("read data", 8'h5A, rd[7:0])
    absent <= 1'b1;
    apb(1'b1, `OFS_EEPROM_COMMAND, 32'hB000_0031);
    wait_idle();
    `CHK("timeout", 1'b1, rd[16])
    absent <= 1'b0;
    apb(1'b0, 12'h100, 32'h0000_0000);
    `CHK("unmapped", 1'b1, err)
    // A reserved code finishes at once and leaves busy low
    apb(1'b1, `OFS_EEPROM_COMMAND, 32'h9000_0000);
    apb(1'b0, `OFS_EEPROM_COMMAND, 32'h0000_0000);
    `CHK("reserved busy", 1'b0, rd[31])
    `CHK("reserved op", 3'h1, rd[30:28])
    // Long bursts run past the small limit: 255 words, then 251
    exp_on = 1'b0;
    em.mem[17] = `VALID_FLAG;
    em.mem[18] = 8'h03;
    em.mem[20] = 8'hFF;
    em.mem[1041] = 8'h01;
    em.mem[1042] = 8'hFF;
    wr_n = 0;
    apb(1'b1, `OFS_EEPROM_COMMAND, 32'hF000_0000);
    wait_idle();
    `CHK("overflow", 1'b1, rd[17])
    `CHK("words", 506, wr_n)
    // Large strap lifts the limit; the third burst has no words
    apb(1'b1, `OFS_EEPROM_COMMAND, 32'h0002_0000);
    strap <= 1'b1;
    wr_n = 0;
    apb(1'b1, `OFS_EEPROM_COMMAND, 32'hF000_0000);
    wait_idle();
    `CHK("no overflow", 1'b0, rd[17])
    `CHK("all words", 510, wr_n)
    give_verdict();
  end
endmodule // eeprom_register_burst_loader_tb
bind eeprom_register_burst_loader loader_checker chk (.sys_clk(sys_clk), .rst(rst),
  .eeprom_req(eeprom_req), .eeprom_we(eeprom_we), .eeprom_addr(eeprom_addr),
  .eeprom_done(eeprom_done), .eeprom_timeout(eeprom_timeout), .cfg_wr_valid(cfg_wr_valid),
  .switch_a(switch_a), .phy_mgmt_busy(phy_mgmt_busy),
  .eeprom_size_strap(eeprom_size_strap), .device_ready(device_ready));
`default_nettype wire
